// ==== rtl/scr_cfg.svh ====
// Constants for the segmented call and return execution unit
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

// Clock period and time to cycle conversion
`define SCR_CLK_NS 10
`define SCR_CYC(ns) ((ns) / `SCR_CLK_NS)

// Execution times in ns
`define SCR_T_EXIT_NS      2250
`define SCR_T_EXIT_MAP_NS  13500
`define SCR_T_SKIP_NS      2480
`define SCR_T_SKIP_MAP_NS  13730
`define SCR_T_CALL_NS      7200
`define SCR_T_PARAM_NS     1350
`define SCR_T_IND_NS       450
`define SCR_T_DSP_NS       2480
`define SCR_T_ELEM_NS      900
`define SCR_T_MF_IN_NS     1350
`define SCR_T_MF_OUT_NS    900
`define SCR_T_BND_NS       900
`define SCR_T_CAP_NS       1350
`define SCR_T_ADD_NS       900

// Opcodes
`define SCR_OPC_CALLN  16'h8b04
`define SCR_OPC_DSP    16'h8b05
`define SCR_OPC_RETURN_SKIP_ONE_OP  16'h8b0d
`define SCR_OPC_RETURN_SKIP_TWO_OP  16'h8b0e
`define SCR_OPC_EXIT0  16'h8b0f
`define SCR_OPC_FROM_MF 16'h8306
`define SCR_OPC_TO_MF  16'h8307
`define SCR_OPC_FROM_B 16'h8308
`define SCR_OPC_TO_B   16'h8309
`define SCR_OPC_CAP    16'h830a
`define SCR_OPC_ADDQ   16'h830b
`define SCR_OPC_SEL_B  16'h0800

// Stack marker offsets from the frame pointer
`define SCR_OFF_PREV   16'h0000
`define SCR_OFF_RETP   16'h0001
`define SCR_OFF_SEG    16'h0003
`define SCR_OFF_PARAM  16'h0006
`define SCR_CALLN_RET  16'h0006

// Masks, vector and reset values
`define SCR_DSP_MASK   16'h0fff
`define SCR_SEG_VEC    16'h000b
`define SCR_RST_MODE   1'b1

`endif

// ==== rtl/scr_pkg.sv ====
// Types shared by the segmented call and return execution unit
`default_nettype none
package scr_pkg;

  typedef enum logic [3:0] {
    op_none, op_calln, op_dsp, op_exit0, op_return_skip_one_op, op_return_skip_two_op, op_to_mf,
    op_from_mf, op_to_bnd, op_from_bnd, op_from_cap, op_addq
  } scr_op_t;

  // Gray codes along the usual path
  typedef enum logic [3:0] {
    st_idle = 4'h0, st_ret = 4'h1, st_seg = 4'h3, st_tbl = 4'h2,
    st_map  = 4'h6, st_prev = 4'h7, st_fin = 4'h5, st_def = 4'h4,
    st_cnt  = 4'hc, st_dwr = 4'hd, st_drd = 4'hf, st_prd = 4'he,
    st_pwr  = 4'ha, st_mk1 = 4'hb, st_mk2 = 4'h9, st_mk3 = 4'h8
  } scr_state_t;

  typedef enum logic [1:0] {sp_data = 2'h0, sp_code = 2'h1, sp_table = 2'h2} scr_space_t;

endpackage : scr_pkg
`default_nettype wire

// ==== rtl/scr_decode.sv ====
// Opcode decoder for the segmented call and return group
`timescale 1ns/100ps
`default_nettype none
`include "scr_cfg.svh"

module scr_decode
  import scr_pkg::*;
(
  input  wire logic [15:0] opcode_in,
  output scr_op_t          op_out,
  output logic             sel_b_out,
  output logic             hit_out
);

  // Full 16-bit match; the A/B pair differs only in bit 11
  always_comb
  begin
    op_out    = op_none;
    sel_b_out = |(opcode_in & `SCR_OPC_SEL_B);
    case (opcode_in)
      `SCR_OPC_CALLN: op_out = op_calln;
      `SCR_OPC_DSP:   op_out = op_dsp;
      `SCR_OPC_EXIT0: op_out = op_exit0;
      `SCR_OPC_RETURN_SKIP_ONE_OP: op_out = op_return_skip_one_op;
      `SCR_OPC_RETURN_SKIP_TWO_OP: op_out = op_return_skip_two_op;
      `SCR_OPC_TO_MF,   `SCR_OPC_TO_MF | `SCR_OPC_SEL_B:   op_out = op_to_mf;
      `SCR_OPC_FROM_MF, `SCR_OPC_FROM_MF | `SCR_OPC_SEL_B: op_out = op_from_mf;
      `SCR_OPC_TO_B,    `SCR_OPC_TO_B | `SCR_OPC_SEL_B:    op_out = op_to_bnd;
      `SCR_OPC_FROM_B,  `SCR_OPC_FROM_B | `SCR_OPC_SEL_B:  op_out = op_from_bnd;
      `SCR_OPC_CAP,     `SCR_OPC_CAP | `SCR_OPC_SEL_B:     op_out = op_from_cap;
      `SCR_OPC_ADDQ,    `SCR_OPC_ADDQ | `SCR_OPC_SEL_B:    op_out = op_addq;
      default: op_out = op_none;
    endcase
    hit_out = (op_out != op_none);
  end

endmodule : scr_decode
`default_nettype wire

// ==== rtl/scr_budget.sv ====
// Cycle budget counter that paces each instruction
`timescale 1ns/100ps
`default_nettype none

module scr_budget #(
  parameter int W = 20
) (
  input  wire logic         mclk_in,
  input  wire logic         rst_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] load_val_in,
  input  wire logic [W-1:0] add_in,
  output logic              expired_out
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // Load wins; added time stretches a running budget
  always_comb
  begin
    if (load_in)
      cnt_next = load_val_in;
    else if (cnt_reg != '0)
      cnt_next = cnt_reg + add_in - W'(1);
    else
      cnt_next = add_in;
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

  assign expired_out = (cnt_reg == '0);

endmodule : scr_budget
`default_nettype wire

// ==== rtl/scr_exec.sv ====
// Execution unit for the segmented call, display store and return group
//
// Overview of operation
// - Constant-entry data call writes new frame plus 6 at procedure entry.
// - Display store first writes current frame pointer at display location.
// - Then dl times: read word at last value, mask 7777B, store next.
// - Return reads return word; bit 15 set maps frame's return segment.
// - Non-resident segment faults to vector 13 octal, P and Q unchanged.
// - Segment fault is lowest priority; pending interrupts cause plain retry.
// - Successful return loads mode and frame from previous word, P from return.
// - Skip returns add one or two to the return address.
// - Accumulator to mode/frame: bits 14..0 to frame, bit 15 sets mode off.
// - Mode/frame to accumulator: frame low, bit 15 one when mode off.
// - Accumulator to bound copies all sixteen bits unchanged.
// - Bound to accumulator copies bound unchanged to A or B.
// - Captured-frame copy returns mode and frame latched at last interrupt.
// - Add-frame adds frame pointer into selected accumulator.
// - Plain return takes 2.25 us, or 13.50 us with mapping.
// - Skip returns take 2.48 us, or 13.73 us with mapping.
// - Call takes 7.20 us plus 1.35 per parameter, 0.45 per indirect.
// - Display store takes 2.48 us plus 0.90 per extra element.
// - Table entry bit 15 means absent; else load page registers from base.
`timescale 1ns/100ps
`default_nettype none
`include "scr_cfg.svh"

module scr_exec
  import scr_pkg::*;
#(
  parameter int CODE_PAGES = 31
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        start_in,
  input  wire logic [15:0] opcode_in,
  input  wire logic [14:0] pc_in,
  input  wire logic [15:0] acc_a_in,
  input  wire logic [15:0] acc_b_in,
  input  wire logic [14:0] next_q_in,
  input  wire logic        irq_pending_in,
  input  wire logic        irq_taken_in,
  input  wire logic        mem_ack_in,
  input  wire logic [15:0] mem_rdata_in,
  output logic             hit_out,
  output logic             busy_out,
  output logic             done_out,
  output logic             retry_out,
  output logic             seg_fault_out,
  output logic [15:0]      fault_vec_out,
  output logic             mem_req_out,
  output logic             mem_we_out,
  output logic [1:0]       mem_space_out,
  output logic [15:0]      mem_addr_out,
  output logic [15:0]      mem_wdata_out,
  output logic             map_we_out,
  output logic [4:0]       map_page_out,
  output logic [13:0]      map_phys_out,
  output logic             acc_we_a_out,
  output logic             acc_we_b_out,
  output logic [15:0]      acc_data_out,
  output logic             pc_we_out,
  output logic [14:0]      pc_data_out,
  output logic [14:0]      q_out,
  output logic             mode_off_out,
  output logic [15:0]      bound_out,
  output logic [15:0]      captured_out
);

  localparam int BW = 20;

  scr_state_t  state_reg, state_next;
  scr_op_t     op_reg, op_next, dec_op;
  logic        selb_reg, selb_next, dec_selb;
  logic [14:0] q_reg, q_next, nq_reg, nq_next, pc_reg, pc_next;
  logic        c_reg, c_next;
  logic [15:0] z_reg, z_next, iq_reg, iq_next, res_reg, res_next;
  logic [15:0] w0_reg, w0_next, w1_reg, w1_next;
  logic [7:0]  cnt_reg, cnt_next, idx_reg, idx_next;
  logic [4:0]  page_reg, page_next;
  logic [13:0] phys_reg, phys_next;
  logic        done_reg, done_next, retry_reg, retry_next, fault_reg, fault_next;
  logic        mwe_reg, mwe_next, awa_reg, awa_next, awb_reg, awb_next;
  logic        pcwe_reg, pcwe_next;
  logic [4:0]  mpage_reg, mpage_next;
  logic [13:0] mphys_reg, mphys_next;
  logic [14:0] pco_reg, pco_next;
  // Memory port state
  logic        req_reg, req_next, we_reg, we_next;
  scr_space_t  sp_reg, sp_next;
  logic [15:0] addr_reg, addr_next, wd_reg, wd_next;
  logic        iss, iss_we;
  scr_space_t  iss_sp;
  logic [15:0] iss_addr, iss_wd;
  // Budget control
  logic          bud_load, bud_done;
  logic [BW-1:0] bud_val, bud_add;
  logic [15:0]   acc_sel, q16, skip, rd_masked;
  logic          ack;

  scr_decode u_decode (
    .opcode_in (opcode_in),
    .op_out    (dec_op),
    .sel_b_out (dec_selb),
    .hit_out   (hit_out)
  );

  scr_budget #(.W(BW)) u_budget (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .load_in     (bud_load),
    .load_val_in (bud_val),
    .add_in      (bud_add),
    .expired_out (bud_done)
  );

  // Budget less one so done lands exactly on the figure
  function automatic logic [BW-1:0] base_cycles(input scr_op_t op);
    case (op)
      op_exit0:               return BW'(`SCR_CYC(`SCR_T_EXIT_NS) - 1);
      op_return_skip_one_op, op_return_skip_two_op:     return BW'(`SCR_CYC(`SCR_T_SKIP_NS) - 1);
      op_calln:               return BW'(`SCR_CYC(`SCR_T_CALL_NS) - 1);
      op_dsp:                 return BW'(`SCR_CYC(`SCR_T_DSP_NS) - 1);
      op_to_mf:               return BW'(`SCR_CYC(`SCR_T_MF_IN_NS) - 1);
      op_from_mf:             return BW'(`SCR_CYC(`SCR_T_MF_OUT_NS) - 1);
      op_to_bnd, op_from_bnd: return BW'(`SCR_CYC(`SCR_T_BND_NS) - 1);
      op_from_cap:            return BW'(`SCR_CYC(`SCR_T_CAP_NS) - 1);
      default:                return BW'(`SCR_CYC(`SCR_T_ADD_NS) - 1);
    endcase
  endfunction : base_cycles

  assign ack       = req_reg & mem_ack_in;
  assign acc_sel   = dec_selb ? acc_b_in : acc_a_in;
  assign q16       = {1'b0, q_reg};
  assign rd_masked = mem_rdata_in & `SCR_DSP_MASK;
  assign skip      = (op_reg == op_return_skip_one_op) ? 16'h0001 : (op_reg == op_return_skip_two_op) ? 16'h0002 : 16'h0000;

  // Sequencer: one memory access at a time, results held until commit
  always_comb
  begin
    state_next = state_reg;  op_next = op_reg;   selb_next = selb_reg;
    q_next = q_reg;          c_next = c_reg;     z_next = z_reg;
    nq_next = nq_reg;        pc_next = pc_reg;   res_next = res_reg;
    w0_next = w0_reg;        w1_next = w1_reg;   cnt_next = cnt_reg;
    idx_next = idx_reg;      page_next = page_reg; phys_next = phys_reg;
    mpage_next = mpage_reg;  mphys_next = mphys_reg; pco_next = pco_reg;
    done_next = 1'b0;  retry_next = 1'b0;  fault_next = 1'b0;  mwe_next = 1'b0;
    awa_next = 1'b0;   awb_next = 1'b0;    pcwe_next = 1'b0;
    iss = 1'b0;  iss_we = 1'b0;  iss_sp = sp_data;  iss_addr = '0;  iss_wd = '0;
    bud_load = 1'b0;  bud_val = '0;  bud_add = '0;
    // Captured frame follows every interrupt taken by the processor
    iq_next = irq_taken_in ? {c_reg, q_reg} : iq_reg;
    case (state_reg)
      st_idle:
        if (start_in && hit_out)
        begin
          op_next = dec_op;  selb_next = dec_selb;  pc_next = pc_in;  nq_next = next_q_in;
          bud_load = 1'b1;
          bud_val = base_cycles(dec_op);
          state_next = st_fin;
          case (dec_op)
            op_exit0, op_return_skip_one_op, op_return_skip_two_op:
            begin
              iss = 1'b1;  iss_addr = q16 + `SCR_OFF_RETP;
              state_next = st_ret;
            end
            op_calln, op_dsp:
            begin
              // The DEF word comes first, the count word second
              iss = 1'b1;  iss_sp = sp_code;
              iss_addr = {1'b0, pc_in} + ((dec_op == op_dsp) ? 16'h0002 : 16'h0001);
              state_next = st_def;
            end
            op_to_mf, op_to_bnd: res_next = acc_sel;
            op_from_mf:  res_next = {c_reg, q_reg};
            op_from_bnd: res_next = z_reg;
            op_from_cap: res_next = iq_reg;
            op_addq:     res_next = acc_sel + q16;
            default:     res_next = res_reg;
          endcase
        end
      st_ret:
        if (ack)
        begin
          w0_next = mem_rdata_in;  iss = 1'b1;
          if (mem_rdata_in[15])
          begin
            iss_addr = q16 + `SCR_OFF_SEG;
            bud_add = BW'(`SCR_CYC(`SCR_T_EXIT_MAP_NS - `SCR_T_EXIT_NS));
            state_next = st_seg;
          end
          else
          begin
            iss_addr = q16 + `SCR_OFF_PREV;
            state_next = st_prev;
          end
        end
      st_seg:
        if (ack)
        begin
          // Table entries are four words apart
          iss = 1'b1;  iss_sp = sp_table;  iss_addr = {6'h00, mem_rdata_in[15:8], 2'b00};
          state_next = st_tbl;
        end
      st_tbl:
        if (ack)
        begin
          if (mem_rdata_in[15])
          begin
            // Other interrupts go first; the return is simply rerun later
            if (irq_pending_in)
              retry_next = 1'b1;
            else
            begin
              fault_next = 1'b1;
              iq_next = {c_reg, q_reg};
            end
            state_next = st_idle;
          end
          else
          begin
            phys_next = mem_rdata_in[13:0];  page_next = 5'h01;
            state_next = st_map;
          end
        end
      st_map:
      begin
        // One page register per cycle, base page untouched
        mwe_next = 1'b1;  mpage_next = page_reg;
        mphys_next = phys_reg + 14'(page_reg) - 14'h0001;
        page_next = page_reg + 5'h01;
        if (page_reg == 5'(CODE_PAGES))
        begin
          iss = 1'b1;  iss_addr = q16 + `SCR_OFF_PREV;
          state_next = st_prev;
        end
      end
      st_prev:
        if (ack)
        begin
          w1_next = mem_rdata_in;
          state_next = st_fin;
        end
      st_def:
        if (ack)
        begin
          if (mem_rdata_in[15])
          begin
            bud_add = BW'(`SCR_CYC(`SCR_T_IND_NS));
            if (irq_pending_in)
            begin
              retry_next = 1'b1;  state_next = st_idle;
            end
            else
            begin
              iss = 1'b1;  iss_addr = {1'b0, mem_rdata_in[14:0]};
            end
          end
          else
          begin
            w0_next = {1'b0, mem_rdata_in[14:0]};
            iss = 1'b1;  iss_sp = sp_code;
            iss_addr = {1'b0, pc_reg} + ((op_reg == op_dsp) ? 16'h0001 : 16'h0002);
            state_next = st_cnt;
          end
        end
      st_cnt:
        if (ack)
        begin
          cnt_next = mem_rdata_in[7:0];  idx_next = 8'h00;  iss = 1'b1;
          if (op_reg == op_dsp)
          begin
            iss_we = 1'b1;  iss_addr = w0_reg;  iss_wd = q16;
            w1_next = q16;  state_next = st_dwr;
          end
          else if (mem_rdata_in[7:0] == 8'h00)
          begin
            iss_we = 1'b1;  iss_addr = {1'b0, nq_reg} + `SCR_OFF_RETP;
            iss_wd = {1'b0, pc_reg} + 16'h0003;
            state_next = st_mk1;
          end
          else
          begin
            iss_sp = sp_code;  iss_addr = {1'b0, pc_reg} + 16'h0003;
            state_next = st_prd;
          end
        end
      st_dwr:
        if (ack)
        begin
          if (idx_reg == cnt_reg)
            state_next = st_fin;
          else if (irq_pending_in)
          begin
            retry_next = 1'b1;  state_next = st_idle;
          end
          else
          begin
            iss = 1'b1;  iss_addr = {1'b0, w1_reg[14:0]};
            bud_add = BW'(`SCR_CYC(`SCR_T_ELEM_NS));
            state_next = st_drd;
          end
        end
      st_drd:
        if (ack)
        begin
          w1_next = rd_masked;  idx_next = idx_reg + 8'h01;
          iss = 1'b1;  iss_we = 1'b1;  iss_wd = rd_masked;
          iss_addr = w0_reg + {8'h00, idx_reg} + 16'h0001;
          state_next = st_dwr;
        end
      st_prd:
        if (ack)
        begin
          iss = 1'b1;
          if (mem_rdata_in[15])
          begin
            bud_add = BW'(`SCR_CYC(`SCR_T_IND_NS));
            iss_addr = {1'b0, mem_rdata_in[14:0]};
          end
          else
          begin
            iss_we = 1'b1;  iss_wd = mem_rdata_in;
            iss_addr = {1'b0, nq_reg} + `SCR_OFF_PARAM + {8'h00, idx_reg};
            state_next = st_pwr;
          end
        end
      st_pwr:
        if (ack)
        begin
          idx_next = idx_reg + 8'h01;
          bud_add = BW'(`SCR_CYC(`SCR_T_PARAM_NS));
          if (idx_reg + 8'h01 == cnt_reg)
          begin
            iss = 1'b1;  iss_we = 1'b1;  iss_addr = {1'b0, nq_reg} + `SCR_OFF_RETP;
            iss_wd = {1'b0, pc_reg} + 16'h0003 + {8'h00, cnt_reg};
            state_next = st_mk1;
          end
          else if (irq_pending_in)
          begin
            retry_next = 1'b1;  state_next = st_idle;
          end
          else
          begin
            iss = 1'b1;  iss_sp = sp_code;
            iss_addr = {1'b0, pc_reg} + 16'h0004 + {8'h00, idx_reg};
            state_next = st_prd;
          end
        end
      st_mk1:
        if (ack)
        begin
          iss = 1'b1;  iss_we = 1'b1;  iss_addr = {1'b0, nq_reg} + `SCR_OFF_PREV;
          iss_wd = {c_reg, q_reg};  state_next = st_mk2;
        end
      st_mk2:
        if (ack)
        begin
          iss = 1'b1;  iss_we = 1'b1;  iss_addr = w0_reg;
          iss_wd = {1'b0, nq_reg} + `SCR_CALLN_RET;
          state_next = st_mk3;
        end
      st_mk3:
        if (ack)
          state_next = st_fin;
      st_fin:
        if (bud_done)
        begin
          done_next = 1'b1;  state_next = st_idle;
          case (op_reg)
            op_exit0, op_return_skip_one_op, op_return_skip_two_op:
            begin
              q_next = w1_reg[14:0];  c_next = w1_reg[15];
              pcwe_next = 1'b1;  pco_next = w0_reg[14:0] + skip[14:0];
            end
            op_calln:
            begin
              q_next = nq_reg;  c_next = 1'b1;
              pcwe_next = 1'b1;  pco_next = w0_reg[14:0] + 15'h0001;
            end
            op_dsp:
            begin
              pcwe_next = 1'b1;  pco_next = pc_reg + 15'h0003;
            end
            op_to_mf:
            begin
              q_next = res_reg[14:0];  c_next = res_reg[15];
            end
            op_to_bnd: z_next = res_reg;
            default:
            begin
              awa_next = ~selb_reg;  awb_next = selb_reg;
            end
          endcase
        end
      default: state_next = st_idle;
    endcase
  end

  // Memory request holds until acknowledged
  always_comb
  begin
    req_next = iss | (req_reg & ~mem_ack_in);
    we_next = iss ? iss_we : we_reg;
    sp_next = iss ? iss_sp : sp_reg;
    addr_next = iss ? iss_addr : addr_reg;
    wd_next = iss ? iss_wd : wd_reg;
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg <= st_idle;  op_reg <= op_none;  selb_reg <= 1'b0;
      q_reg <= '0;  c_reg <= `SCR_RST_MODE;  z_reg <= '0;  iq_reg <= '0;
      nq_reg <= '0;  pc_reg <= '0;  res_reg <= '0;  w0_reg <= '0;  w1_reg <= '0;
      cnt_reg <= '0;  idx_reg <= '0;  page_reg <= '0;  phys_reg <= '0;
      done_reg <= 1'b0;  retry_reg <= 1'b0;  fault_reg <= 1'b0;  mwe_reg <= 1'b0;
      awa_reg <= 1'b0;  awb_reg <= 1'b0;  pcwe_reg <= 1'b0;
      mpage_reg <= '0;  mphys_reg <= '0;  pco_reg <= '0;
      req_reg <= 1'b0;  we_reg <= 1'b0;  sp_reg <= sp_data;  addr_reg <= '0;  wd_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;  op_reg <= op_next;  selb_reg <= selb_next;
      q_reg <= q_next;  c_reg <= c_next;  z_reg <= z_next;  iq_reg <= iq_next;
      nq_reg <= nq_next;  pc_reg <= pc_next;  res_reg <= res_next;
      w0_reg <= w0_next;  w1_reg <= w1_next;
      cnt_reg <= cnt_next;  idx_reg <= idx_next;  page_reg <= page_next;
      phys_reg <= phys_next;
      done_reg <= done_next;  retry_reg <= retry_next;  fault_reg <= fault_next;
      mwe_reg <= mwe_next;  awa_reg <= awa_next;  awb_reg <= awb_next;
      pcwe_reg <= pcwe_next;
      mpage_reg <= mpage_next;  mphys_reg <= mphys_next;  pco_reg <= pco_next;
      req_reg <= req_next;  we_reg <= we_next;  sp_reg <= sp_next;
      addr_reg <= addr_next;  wd_reg <= wd_next;
    end
  end

  // Outputs straight from registers; the fault vector is a constant
  assign busy_out      = (state_reg != st_idle);
  assign done_out      = done_reg;
  assign retry_out     = retry_reg;
  assign seg_fault_out = fault_reg;
  assign fault_vec_out = `SCR_SEG_VEC;
  assign mem_req_out   = req_reg;
  assign mem_we_out    = we_reg;
  assign mem_space_out = sp_reg;
  assign mem_addr_out  = addr_reg;
  assign mem_wdata_out = wd_reg;
  assign map_we_out    = mwe_reg;
  assign map_page_out  = mpage_reg;
  assign map_phys_out  = mphys_reg;
  assign acc_we_a_out  = awa_reg;
  assign acc_we_b_out  = awb_reg;
  assign acc_data_out  = res_reg;
  assign pc_we_out     = pcwe_reg;
  assign pc_data_out   = pco_reg;
  assign q_out         = q_reg;
  assign mode_off_out  = c_reg;
  assign bound_out     = z_reg;
  assign captured_out  = iq_reg;

endmodule : scr_exec
`default_nettype wire

// ==== bench/scr_exec_checker.sv ====
// Port assertions for the execution unit
`timescale 1ns/100ps
`default_nettype none
module scr_exec_checker (
  input wire logic        mclk_in, rst_in, start_in, hit_out, busy_out, done_out,
  input wire logic        seg_fault_out, acc_we_a_out, pc_we_out, irq_pending_in,
  input wire logic        mode_off_out, acc_we_b_out,
  input wire logic [15:0] opcode_in, acc_a_in, acc_data_out, bound_out,
  input wire logic [15:0] captured_out, fault_vec_out,
  input wire logic [14:0] q_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Accepted start of one opcode
  sequence s_go(logic [15:0] op);
    start_in && hit_out && !busy_out && opcode_in == op;
  endsequence
  a_bound_copy: assert property (s_go(16'h8309) |-> ##91 done_out &&
    bound_out == $past(acc_a_in, 91)) else $error("bound copy wrong");
  a_mode_load: assert property (s_go(16'h8307) |-> ##136 done_out &&
    {mode_off_out, q_out} == $past(acc_a_in, 136)) else $error("mode load wrong");
  a_mode_read: assert property (s_go(16'h8306) |-> ##91 acc_we_a_out &&
    acc_data_out == {mode_off_out, q_out}) else $error("mode read wrong");
  a_bound_read: assert property (s_go(16'h8b08) |-> ##91 acc_we_b_out &&
    acc_data_out == bound_out) else $error("bound read wrong");
  a_frame_add: assert property (s_go(16'h830b) |-> ##91 acc_we_a_out &&
    acc_data_out == $past(acc_a_in, 91) + {1'b0, q_out}) else $error("add wrong");
  a_saved_read: assert property (s_go(16'h8b0a) |-> ##136 acc_we_b_out &&
    acc_data_out == captured_out) else $error("saved frame read wrong");
  a_fault_vec: assert property (seg_fault_out |-> fault_vec_out == 16'h000b &&
    !pc_we_out && $stable(q_out)) else $error("fault commits state");
  a_fault_last: assert property (seg_fault_out |->
    !$past(irq_pending_in)) else $error("fault beat pending interrupt");
endmodule : scr_exec_checker
`default_nettype wire

// ==== bench/scr_mem_model.sv ====
// Behavioural memory and segment table behind the execution unit
`timescale 1ns/100ps
`default_nettype none
module scr_mem_model (
  input wire logic        mclk_in, req_in, we_in, slow_in,
  input wire logic [1:0]  space_in,
  input wire logic [15:0] addr_in, wdata_in,
  output logic            ack_out,
  output logic [15:0]     rdata_out
);
  logic [15:0] mem [0:2][0:255];
  logic        hold_q = 1'b0;
  wire         go = req_in && !ack_out && (!slow_in || hold_q);
  initial {ack_out, rdata_out} = 17'h0;
  // Slow mode waits a cycle; data toggles outside ack so stale values never match
  always @(posedge mclk_in)
  begin
    ack_out <= go;
    hold_q <= slow_in && req_in && !ack_out && !hold_q;
    rdata_out <= ~rdata_out;
    if (go)
    begin
      rdata_out <= mem[space_in][addr_in[7:0]];
      if (we_in) mem[space_in][addr_in[7:0]] <= wdata_in;
    end
  end
endmodule : scr_mem_model
`default_nettype wire

// ==== bench/scr_exec_tb.sv ====
// Self-checking bench for the execution unit
`timescale 1ns/100ps
`default_nettype none
module scr_exec_tb;
  logic mclk_in = 0, rst_in = 1, start_in = 0, irq_pending_in = 0, irq_taken_in = 0, slow = 0;
  logic [15:0] opcode_in = 16'h0, acc_a_in = 16'h0, acc_b_in = 16'h0, mem_rdata_in, got;
  logic [14:0] pc_in = 15'h0, next_q_in = 15'h0, pc_data_out, q_out;
  logic mem_ack_in, hit_out, busy_out, done_out, retry_out, seg_fault_out, mem_req_out;
  logic mem_we_out, map_we_out, acc_we_a_out, acc_we_b_out, pc_we_out, mode_off_out;
  logic [1:0] mem_space_out;
  logic [4:0] map_page_out;
  logic [13:0] map_phys_out, last_phys;
  logic [15:0] fault_vec_out, mem_addr_out, mem_wdata_out, acc_data_out, bound_out, captured_out;
  logic [15:0] xop [3] = '{16'h8b0f, 16'h8b0d, 16'h8b0e};
  int failures = 0, cmp_count = 0, cyc, nmap;
  scr_exec dut (.*);
  scr_mem_model mem_i (.mclk_in(mclk_in), .req_in(mem_req_out), .we_in(mem_we_out),
    .slow_in(slow), .space_in(mem_space_out), .addr_in(mem_addr_out),
    .wdata_in(mem_wdata_out), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
  always #5 mclk_in = ~mclk_in;
  // Page register writes of the last mapping
  always @(posedge mclk_in)
    if (map_we_out)
    begin
      nmap++;
      last_phys = map_phys_out;
    end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  // One instruction; cycles counted from the start edge, bounded wait
  task automatic run(logic [15:0] op, logic [15:0] a);
    @(negedge mclk_in);
    opcode_in = op;
    acc_a_in = a;
    acc_b_in = a;
    start_in = 1;
    nmap = 0;
    @(negedge mclk_in);
    start_in = 0;
    cyc = 0;
    while (!(done_out | retry_out | seg_fault_out) && cyc < 3000)
    begin
      @(negedge mclk_in);
      cyc++;
    end
    got = acc_data_out;
  endtask : run
  initial
  begin
    #200000;
    failures++;
    wrap_up();
  end
  initial
  begin
    repeat (2) @(negedge mclk_in);
    rst_in = 0;
    check("hit", hit_out, 0);
    run(16'h8309, 16'h8123);
    check("bound", bound_out, 16'h8123);
    run(16'h8b08, 0);
    check("bound_b", got, 16'h8123);
    run(16'h8b07, 16'h8042);
    check("mode_frame", {mode_off_out, q_out}, 16'h8042);
    run(16'h8306, 0);
    check("mf_read", got, 16'h8042);
    irq_taken_in = 1;
    @(negedge mclk_in);
    irq_taken_in = 0;
    run(16'h8307, 16'h0040);
    run(16'h8b0a, 0);
    check("saved", got, 16'h8042);
    run(16'h830b, 16'h0010);
    check("add", got, 16'h0050);
    mem_i.mem[0][8'h41] = 16'h0200;
    mem_i.mem[0][8'h40] = 16'h8030;
    for (int k = 0; k < 3; k++)
    begin
      run(16'h8307, 16'h0040);
      run(xop[k], 0);
      check("exit_pc", pc_data_out, 16'h0200 + k);
      check("exit_frame", {mode_off_out, q_out}, 16'h8030);
      check("exit_time", cyc, k ? 248 : 225);
    end
    mem_i.mem[0][8'h41] = 16'h8200;
    mem_i.mem[0][8'h43] = 16'h0500;
    mem_i.mem[2][8'h14] = 16'h8000;
    irq_pending_in = 1;
    run(16'h8307, 16'h0040);
    run(16'h8b0f, 0);
    check("retry", retry_out, 1);
    irq_pending_in = 0;
    run(16'h8b0f, 0);
    check("fault", seg_fault_out, 1);
    check("iq", captured_out, 16'h0040);
    mem_i.mem[2][8'h14] = 16'h0040;
    run(16'h8b0f, 0);
    check("pages", nmap, 31);
    check("phys", last_phys, 14'h005e);
    check("page", map_page_out, 31);
    check("map_pc", pc_data_out, 15'h0200);
    check("map_time", cyc, 1350);
    run(16'h8307, 16'h0020);
    pc_in = 15'h0010;
    mem_i.mem[1][8'h12] = 16'h0080;
    mem_i.mem[1][8'h11] = 16'h0002;
    mem_i.mem[0][8'h20] = 16'hf0a3;
    mem_i.mem[0][8'ha3] = 16'h1234;
    run(16'h8b05, 0);
    check("disp0", mem_i.mem[0][8'h80], 16'h0020);
    check("disp2", {mem_i.mem[0][8'h81], mem_i.mem[0][8'h82]}, 32'h00a30234);
    check("disp_time", cyc, 428);
    pc_in = 15'h0030;
    next_q_in = 15'h0060;
    mem_i.mem[1][8'h31] = 16'h0090;
    mem_i.mem[1][8'h32] = 16'h0001;
    mem_i.mem[1][8'h33] = 16'h0044;
    run(16'h8b04, 0);
    check("entry_ret", mem_i.mem[0][8'h90], 16'h0066);
    check("param", mem_i.mem[0][8'h66], 16'h0044);
    check("call_time", cyc, 855);
    slow = 1;
    run(16'h8307, 16'h0040);
    run(16'h8b0d, 0);
    check("slow_pc", pc_data_out, 15'h0201);
    wrap_up();
  end
endmodule : scr_exec_tb
bind scr_exec scr_exec_checker u_chk (.*);
`default_nettype wire
